// ===== bsl_exec.sv
// Operation
// - opcode 00112 multiplies accumulator by ten modulo 4095, one cycle, pc plus one.
// - opcode 00113 multiplies accumulator by hundred modulo 4095, one cycle, pc plus one.
// - In extended mode, both scaling multiplies clear accumulator bit 12.
// - Variable shifts move accumulator, extension or pair by low field count.
// - Every variable left shift is circular into bit zero.
// - Every variable right shift extends the sign and drops bit zero.
// - Shift of n takes one cycle up to seven, else n minus six.
// - Variable shifts always work on 13-bit registers in any mode.
// - Short bank opcodes load bank x into selected controls in one cycle.
// - Loading the relative bank jumps to the accumulator address, else pc plus one.
// - Bank control instructions leave the accumulator unchanged.
// - Opcode 10103 loads four banks from the pair and jumps, two cycles.
// - Wide bank opcodes load bank ZZ; relative forms jump; channel form per channel.
// - A buffer bank change is accepted even while that buffer transfers.
// - Clear buffers halts transfers without any buffer-complete interrupt.
// - A cleared channel disconnects and ignores data until the record ends.
// - Unlock takes effect only after the following instruction completes.
// - Lock level takes effect after the next instruction; entry events lock too.
// - Level zero masks all interrupts, others one channel, independently.
// - In compatibility mode plain unlock also releases level one.
// - Buffered input start jumps if busy, else starts and skips one word.
`timescale 1ns/10ps
module bsl_exec #(
  parameter int MEM_DIV = bsl_pkg::MEM_DIV
) (
  input wire logic mclk_in, // Processor clock.
  input wire logic rstn_in, // Master clear, active low.
  input wire logic instr_valid_in, // Instruction offered.
  input wire logic [14:0] instr_word_in, // Opcode word.
  input wire logic [14:0] instr_word2_in, // Second word of the instruction.
  input wire logic lock_entry_in, // Interrupt entry or external function/connect.
  input wire logic [7:1] chan_busy_in, // Channel busy, from the channels.
  output logic instr_ready_out, // Instruction may be offered.
  output logic instr_done_out, // Instruction completed.
  output logic [14:0] pc_out, // Program counter.
  output bsl_pkg::bsl_banks_t banks_out, // Bank controls.
  output bsl_pkg::bsl_chb_t chan_bank_out, // Per-channel bank controls.
  output logic [7:0] lockout_out, // Lockout levels 0..7.
  output logic [7:1] chan_start_out, // Start buffered input.
  output logic [7:1] chan_clear_out, // Halt and disconnect.
  output logic [7:1] chan_ignore_out, // Drop data from channel.
  output logic [7:1] chan_complete_out, // Buffer-complete interrupt.
  input wire logic hsel, // AHB select.
  input wire logic [31:0] haddr, // AHB address.
  input wire logic [1:0] htrans, // AHB transfer type.
  input wire logic hwrite, // AHB write.
  input wire logic [2:0] hsize, // AHB size, word only.
  input wire logic [31:0] hwdata, // AHB write data.
  input wire logic hready, // AHB ready in.
  output logic [31:0] hrdata, // AHB read data.
  output logic hreadyout, // AHB ready out.
  output logic hresp // AHB response.
);

  bsl_pkg::bsl_regs_t s_r;
  bsl_pkg::bsl_regs_t s_nxt;

  // ----------------------------------------
  // Arithmetic helpers
  // ----------------------------------------

  // End-around fold of a product into 12-bit ones' complement.
  function automatic logic [11:0] fold(input logic [18:0] p);
    logic [12:0] s;
    s = {1'b0, p[11:0]} + {6'h00, p[18:12]};
    return s[11:0] + {11'h000, s[12]};
  endfunction : fold

  function automatic logic [25:0] vshift(input logic [25:0] v, input logic wide,
                                         input logic left, input logic [5:0] n);
    logic [25:0] r;
    r = v;
    for (int i = 0; i < 63; i++) begin
      if (i < int'(n)) begin
        if (left) begin
          r = wide ? {r[24:0], r[25]} : {13'h0000, r[11:0], r[12]};
        end else begin
          r = wide ? {r[25], r[25:1]} : {13'h0000, r[12], r[12:1]};
        end
      end
    end
    return r;
  endfunction : vshift

  // ----------------------------------------
  // Decode and next state
  // ----------------------------------------

  logic accept;
  logic [8:0] fcode;
  logic [2:0] sub;
  logic [2:0] low;
  logic [5:0] ee;
  logic [7:1] ymask;
  logic [7:1] fall;
  logic [25:0] sh;
  logic [11:0] prod;
  logic [5:0] cyc;
  logic is_shift;
  logic is_bank;
  logic bus_wr;

  assign accept = (s_r.st == bsl_pkg::ST_IDLE) && instr_valid_in;
  assign fcode = instr_word_in[14:6];
  assign ee = instr_word_in[5:0];
  assign sub = instr_word_in[5:3];
  assign low = instr_word_in[2:0];
  // Bit y of the mask stands for channel y, so the one-hot value drops its unused bit 0.
  assign ymask = (low == 3'h0) ? 7'h00 : 7'((8'h01 << low) >> 1);
  assign bus_wr = s_r.hsel_d && s_r.hwr_d;

  always_comb begin
    s_nxt = s_r;
    sh = 26'h000_0000;
    prod = 12'h000;
    cyc = 6'h01;
    is_shift = 1'b0;
    is_bank = 1'b0;
    s_nxt.done = 1'b0;
    s_nxt.clr = 7'h00;
    s_nxt.start = 7'h00;
    s_nxt.cmpl = 7'h00;
    s_nxt.bsy1 = chan_busy_in;
    s_nxt.bsy2 = s_r.bsy1;
    s_nxt.bsyp = s_r.bsy2;
    s_nxt.div = (int'(s_r.div) == MEM_DIV - 1) ? 8'h00 : s_r.div + 8'h01;
    fall = s_r.bsyp & ~s_r.bsy2;
    // completion only for transfers never cleared
    s_nxt.cmpl = s_r.started & fall;
    s_nxt.started = s_r.started & ~fall;
    s_nxt.ignore = s_r.ignore & ~fall;

    if (accept) begin
      s_nxt.st = bsl_pkg::ST_EXEC;
      s_nxt.cnt = 6'h00;
      s_nxt.pc = s_r.pc + 15'h0001;
      s_nxt.stg_v = 1'b0;
      if (instr_word_in == bsl_pkg::OP_TIMES_TEN ||
          instr_word_in == bsl_pkg::OP_TIMES_HUNDRED) begin
        prod = fold({7'h00, s_r.acc[11:0]} *
                    ((instr_word_in == bsl_pkg::OP_TIMES_TEN) ? 19'h0_000A : 19'h0_0064));
        // bit 12 cleared in extended mode
        s_nxt.acc = {s_r.gmode ? 1'b0 : prod[11], prod};
      end else if (fcode == bsl_pkg::F_ACC_RS || fcode == bsl_pkg::F_ACC_LS ||
                   fcode == bsl_pkg::F_EXT_RS || fcode == bsl_pkg::F_EXT_LS ||
                   fcode == bsl_pkg::F_PAIR_RS || fcode == bsl_pkg::F_PAIR_LS) begin
        is_shift = 1'b1;
        sh = vshift((fcode[4:3] == 2'h3) ? {s_r.acc, s_r.ext} :
                    {13'h0000, (fcode[4:3] == 2'h1) ? s_r.acc : s_r.ext},
                    fcode[4:3] == 2'h3, fcode[2], ee);
        if (fcode[4:3] == 2'h3) begin
          s_nxt.acc = sh[25:13];
          s_nxt.ext = sh[12:0];
        end else if (fcode[4:3] == 2'h1) begin
          s_nxt.acc = sh[12:0];
        end else begin
          s_nxt.ext = sh[12:0];
        end
        cyc = (int'(ee) <= bsl_pkg::SHIFT_FREE) ? 6'h01 : ee - 6'(bsl_pkg::SHIFT_FREE - 1);
      end else if (fcode == bsl_pkg::F_BANK && sub != 3'h0) begin
        is_bank = 1'b1;
        if (sub[0]) s_nxt.banks.rel = {3'h0, low};
        if (sub[1]) s_nxt.banks.ind = {3'h0, low};
        if (sub[2]) s_nxt.banks.dir = {3'h0, low};
        if (sub[0]) s_nxt.pc = {2'h0, s_r.acc};
      end else if (fcode == bsl_pkg::F_MISC && sub == bsl_pkg::S_BUF_BANK) begin
        is_bank = 1'b1;
        s_nxt.banks.bbuf = {3'h0, low};
      end else if (instr_word_in == bsl_pkg::OP_PAIR_TO_BANKS_JUMP) begin
        is_bank = 1'b1;
        s_nxt.banks = {1'b0, s_r.acc[10:6], 1'b0, s_r.acc[4:0],
                       1'b0, s_r.ext[10:6], 1'b0, s_r.ext[4:0]};
        s_nxt.pc = instr_word2_in;
        cyc = 6'h02;
      end else if (fcode == bsl_pkg::F_CHAN && sub == bsl_pkg::S_CHAN_BANK) begin
        is_bank = 1'b1;
        for (int y = 1; y <= 7; y++) begin
          if (ymask[y]) s_nxt.chb[y] = instr_word2_in[5:0];
        end
        s_nxt.pc = s_r.pc + 15'h0002;
        cyc = 6'h02;
      end else if (fcode == bsl_pkg::F_REL_WIDE_J || fcode == bsl_pkg::F_DIR_REL_WIDE_J ||
                   fcode == bsl_pkg::F_DIR_WIDE || fcode == bsl_pkg::F_IND_WIDE) begin
        is_bank = 1'b1;
        if (fcode == bsl_pkg::F_IND_WIDE) s_nxt.banks.ind = ee;
        if (fcode == bsl_pkg::F_DIR_WIDE || fcode == bsl_pkg::F_DIR_REL_WIDE_J) s_nxt.banks.dir = ee;
        if (fcode == bsl_pkg::F_REL_WIDE_J || fcode == bsl_pkg::F_DIR_REL_WIDE_J) begin
          s_nxt.banks.rel = ee;
          s_nxt.pc = instr_word2_in;
          cyc = 6'h02;
        end
      end else if (instr_word_in == bsl_pkg::OP_CLEAR_BUFFERS ||
                   (fcode == bsl_pkg::F_LOCK && sub == bsl_pkg::S_CLEAR)) begin
        s_nxt.clr = (instr_word_in == bsl_pkg::OP_CLEAR_BUFFERS) ? 7'h7F : ymask;
        s_nxt.started = s_nxt.started & ~s_nxt.clr;
        s_nxt.ignore = s_nxt.ignore | (s_nxt.clr & s_r.bsy2);
      end else if (instr_word_in == bsl_pkg::OP_UNLOCK_INTERRUPTS ||
                   (fcode == bsl_pkg::F_LOCK && (sub == bsl_pkg::S_UNLOCK || sub == bsl_pkg::S_LOCK))) begin
        s_nxt.stg_v = 1'b1;
        s_nxt.stg_set = (fcode == bsl_pkg::F_LOCK) && (sub == bsl_pkg::S_LOCK);
        s_nxt.stg_mask = 8'(9'h001 << low);
        if (instr_word_in == bsl_pkg::OP_UNLOCK_INTERRUPTS) begin
          s_nxt.stg_mask = s_r.gmode ? 8'h01 : 8'h03;
        end
      end else if (instr_word_in == bsl_pkg::OP_START_BUFFERED_INPUT ||
                   (fcode == bsl_pkg::F_CHAN && sub == bsl_pkg::S_CHAN_INPUT)) begin
        if (|(((instr_word_in == bsl_pkg::OP_START_BUFFERED_INPUT) ? 7'h01 : ymask) &
              (s_r.started | s_r.bsy2))) begin
          s_nxt.pc = instr_word2_in;
          cyc = 6'h02;
        end else begin
          s_nxt.start = (instr_word_in == bsl_pkg::OP_START_BUFFERED_INPUT) ? 7'h01 : ymask;
          s_nxt.started = s_nxt.started | s_nxt.start;
          s_nxt.pc = s_r.pc + 15'h0002;
        end
      end
      s_nxt.need = cyc;
    end else if (s_r.st == bsl_pkg::ST_EXEC && int'(s_r.div) == MEM_DIV - 1) begin
      s_nxt.cnt = s_r.cnt + 6'h01;
      // completes after the counted memory cycles
      if (s_r.cnt + 6'h01 == s_r.need) begin
        s_nxt.st = bsl_pkg::ST_IDLE;
        s_nxt.done = 1'b1;
        // unlock waits for the next completion
        // lock waits for the next completion
        if (s_r.pend_v) begin
          s_nxt.lock = s_r.pend_set ? (s_r.lock | s_r.pend_mask) : (s_r.lock & ~s_r.pend_mask);
        end
        s_nxt.pend_v = s_r.stg_v;
        s_nxt.pend_set = s_r.stg_set;
        s_nxt.pend_mask = s_r.stg_mask;
      end
    end
    // entry events lock at once and win over a clear
    if (lock_entry_in) s_nxt.lock[0] = 1'b1;

    // Bus writes take priority over the instruction, software owns setup.
    if (bus_wr) begin
      case (s_r.haddr_d)
        bsl_pkg::ADDR_ACC: s_nxt.acc = hwdata[12:0];
        bsl_pkg::ADDR_EXT: s_nxt.ext = hwdata[12:0];
        bsl_pkg::ADDR_PC: s_nxt.pc = hwdata[14:0];
        bsl_pkg::ADDR_MODE: s_nxt.gmode = hwdata[0];
        default: ;
      endcase
    end
    s_nxt.hsel_d = hsel && htrans[1] && hready;
    s_nxt.hwr_d = hwrite;
    s_nxt.haddr_d = {haddr[7:2], 2'h0};
    case ({haddr[7:2], 2'h0})
      bsl_pkg::ADDR_ACC: s_nxt.rdata = {19'h0_0000, s_r.acc};
      bsl_pkg::ADDR_EXT: s_nxt.rdata = {19'h0_0000, s_r.ext};
      bsl_pkg::ADDR_PC: s_nxt.rdata = {17'h0_0000, s_r.pc};
      bsl_pkg::ADDR_MODE: s_nxt.rdata = {31'h0000_0000, s_r.gmode};
      bsl_pkg::ADDR_BANKS: s_nxt.rdata = {8'h00, s_r.banks};
      bsl_pkg::ADDR_LOCK: s_nxt.rdata = {23'h00_0000, s_r.st == bsl_pkg::ST_EXEC, s_r.lock};
      bsl_pkg::ADDR_CHAN: s_nxt.rdata = {1'b0, s_r.ignore, 1'b0, s_r.started, 8'h00, 1'b0, s_r.bsy2};
      default: s_nxt.rdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    // master clear zeroes banks and lockouts
    if (!rstn_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign instr_ready_out = (s_r.st == bsl_pkg::ST_IDLE);
  assign instr_done_out = s_r.done;
  assign pc_out = s_r.pc;
  assign banks_out = s_r.banks;
  assign chan_bank_out = s_r.chb;
  assign lockout_out = s_r.lock;
  assign chan_start_out = s_r.start;
  assign chan_clear_out = s_r.clr;
  assign chan_ignore_out = s_r.ignore;
  assign chan_complete_out = s_r.cmpl;
  assign hrdata = s_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------
  // Checks
  // ----------------------------------------

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  chk_ten_pc_step: assert property (
    accept && instr_word_in == bsl_pkg::OP_TIMES_TEN && !bus_wr |=> s_r.pc == $past(s_r.pc) + 15'h0001)
    else $error("times ten did not step pc");
  chk_hundred_bit_clear: assert property (
    accept && instr_word_in == bsl_pkg::OP_TIMES_HUNDRED && s_r.gmode && !bus_wr |=> !s_r.acc[12])
    else $error("bit 12 set after scaling in extended mode");
  chk_shift_cycle_count: assert property (
    s_r.st == bsl_pkg::ST_EXEC && s_r.cnt + 6'h01 != s_r.need |=> !s_r.done)
    else $error("instruction ended before its cycle count");
  chk_bank_acc_kept: assert property (
    accept && is_bank && !bus_wr |=> $stable(s_r.acc))
    else $error("bank instruction changed accumulator");
  chk_rel_jump_target: assert property (
    accept && fcode == bsl_pkg::F_BANK && sub[0] && !bus_wr |=> s_r.pc == {2'h0, $past(s_r.acc)})
    else $error("relative bank load did not jump to accumulator");
  chk_lock_deferred: assert property (
    s_r.st == bsl_pkg::ST_EXEC && s_nxt.done && !s_r.pend_v && !lock_entry_in |=> $stable(s_r.lock))
    else $error("lock applied at its own completion");
  chk_clear_no_complete: assert property (
    |s_r.clr |=> (s_r.started & $past(s_r.clr)) == 7'h00)
    else $error("cleared channel still marked started");
  chk_busy_input_jump: assert property (
    accept && instr_word_in == bsl_pkg::OP_START_BUFFERED_INPUT && (s_r.started[1] || s_r.bsy2[1])
    && !bus_wr |=> s_r.start == 7'h00 && s_r.pc == $past(instr_word2_in) && s_r.need == 6'h02)
    else $error("busy input start did not jump");

endmodule : bsl_exec

// ===== bsl_pkg.sv
package bsl_pkg;
  // Data path and bank widths.
  localparam int REG_W = 13;
  localparam int PAIR_W = 26;
  localparam int WORD_W = 15;
  localparam int BANK_W = 6;
  // Clock cycles per memory cycle, and the shift count that still fits one cycle.
  localparam int MEM_DIV = 4;
  localparam int SHIFT_FREE = 7;
  // Whole-word opcodes.
  localparam logic [14:0] OP_TIMES_TEN = 15'h004A;
  localparam logic [14:0] OP_TIMES_HUNDRED = 15'h004B;
  localparam logic [14:0] OP_CLEAR_BUFFERS = 15'h0044;
  localparam logic [14:0] OP_UNLOCK_INTERRUPTS = 15'h0050;
  localparam logic [14:0] OP_START_BUFFERED_INPUT = 15'h0E80;
  localparam logic [14:0] OP_PAIR_TO_BANKS_JUMP = 15'h1043;
  // Upper nine opcode bits of the grouped forms.
  localparam logic [8:0] F_BANK = 9'h000;
  localparam logic [8:0] F_MISC = 9'h001;
  localparam logic [8:0] F_CHAN = 9'h040;
  localparam logic [8:0] F_LOCK = 9'h041;
  localparam logic [8:0] F_ACC_RS = 9'h04B;
  localparam logic [8:0] F_ACC_LS = 9'h04F;
  localparam logic [8:0] F_EXT_RS = 9'h053;
  localparam logic [8:0] F_EXT_LS = 9'h057;
  localparam logic [8:0] F_PAIR_RS = 9'h05B;
  localparam logic [8:0] F_PAIR_LS = 9'h05F;
  localparam logic [8:0] F_REL_WIDE_J = 9'h063;
  localparam logic [8:0] F_DIR_REL_WIDE_J = 9'h067;
  localparam logic [8:0] F_DIR_WIDE = 9'h06B;
  localparam logic [8:0] F_IND_WIDE = 9'h06F;
  // Sub-codes in opcode bits 5..3.
  localparam logic [2:0] S_BUF_BANK = 3'h4;
  localparam logic [2:0] S_CHAN_BANK = 3'h1;
  localparam logic [2:0] S_CHAN_INPUT = 3'h6;
  localparam logic [2:0] S_UNLOCK = 3'h2;
  localparam logic [2:0] S_LOCK = 3'h4;
  localparam logic [2:0] S_CLEAR = 3'h7;
  // Register byte offsets.
  localparam logic [7:0] ADDR_ACC = 8'h00;
  localparam logic [7:0] ADDR_EXT = 8'h04;
  localparam logic [7:0] ADDR_PC = 8'h08;
  localparam logic [7:0] ADDR_MODE = 8'h0C;
  localparam logic [7:0] ADDR_BANKS = 8'h10;
  localparam logic [7:0] ADDR_LOCK = 8'h14;
  localparam logic [7:0] ADDR_CHAN = 8'h18;
  typedef enum logic {ST_IDLE, ST_EXEC} bsl_state_t;
  typedef struct packed {
    logic [BANK_W-1:0] bbuf;
    logic [BANK_W-1:0] dir;
    logic [BANK_W-1:0] ind;
    logic [BANK_W-1:0] rel;
  } bsl_banks_t;
  typedef logic [7:1][BANK_W-1:0] bsl_chb_t;
  typedef struct packed {
    bsl_state_t st;
    logic [REG_W-1:0] acc;
    logic [REG_W-1:0] ext;
    logic [WORD_W-1:0] pc;
    logic gmode;
    bsl_banks_t banks;
    bsl_chb_t chb;
    logic [7:0] lock;
    logic stg_v;
    logic stg_set;
    logic [7:0] stg_mask;
    logic pend_v;
    logic pend_set;
    logic [7:0] pend_mask;
    logic [7:1] started;
    logic [7:1] ignore;
    logic [7:1] clr;
    logic [7:1] start;
    logic [7:1] cmpl;
    logic [7:1] bsy1;
    logic [7:1] bsy2;
    logic [7:1] bsyp;
    logic [7:0] div;
    logic [5:0] cnt;
    logic [5:0] need;
    logic done;
    logic hsel_d;
    logic hwr_d;
    logic [7:0] haddr_d;
    logic [31:0] rdata;
  } bsl_regs_t;
endpackage : bsl_pkg

// ===== bsl_chan_model.sv
`timescale 1ns/10ps
module bsl_chan_model #(
  parameter int REC_LEN = 12
) (
  input wire logic clk_in, // Clock.
  input wire logic rstn_in, // Master clear, active low.
  input wire logic [7:1] start_in, // Start of a record transfer.
  output logic [7:1] busy_out // Equipment busy.
);
  // ----------------------------------------
  // Record transfer
  // ----------------------------------------
  int left_q [7:1];
  // busy outlives a clear
  // A clear does not stop the equipment, so busy runs on to the end of the record.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    for (int c = 1; c <= 7; c++) begin
      if (!rstn_in) begin
        left_q[c] <= 0;
      end else if (start_in[c]) begin
        left_q[c] <= REC_LEN;
      end else if (left_q[c] > 0) begin
        left_q[c] <= left_q[c] - 1;
      end
    end
  end
  always_comb begin
    for (int c = 1; c <= 7; c++) begin
      busy_out[c] = left_q[c] > 0;
    end
  end
endmodule : bsl_chan_model

// ===== test_bsl_exec.sv
`timescale 1ns/10ps
module test_bsl_exec;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic instr_valid_in = 1'b0;
  logic lock_entry_in = 1'b0;
  logic [14:0] instr_word_in = 15'h0000;
  logic [14:0] instr_word2_in = 15'h0000;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hready, hreadyout, hresp, instr_ready_out, instr_done_out;
  logic [31:0] hrdata, q;
  logic [14:0] pc_out, nop, w;
  logic [7:0] lockout_out;
  logic [7:1] chan_busy_in, chan_start_out, chan_clear_out, chan_ignore_out, chan_complete_out;
  bsl_pkg::bsl_banks_t banks_out, eb;
  bsl_pkg::bsl_chb_t chan_bank_out;
  logic [25:0] r, v;
  logic [8:0] sop [6] = '{bsl_pkg::F_ACC_RS, bsl_pkg::F_ACC_LS, bsl_pkg::F_EXT_RS, bsl_pkg::F_EXT_LS,
    bsl_pkg::F_PAIR_RS, bsl_pkg::F_PAIR_LS};
  logic [8:0] wop [4] = '{bsl_pkg::F_REL_WIDE_J, bsl_pkg::F_DIR_REL_WIDE_J, bsl_pkg::F_DIR_WIDE, bsl_pkg::F_IND_WIDE};
  int scnt [6] = '{3, 9, 7, 8, 13, 20};
  int num_errors = 0;
  int n_checks = 0;
  int cyc_cnt = 0;
  int cmpl_cnt [7:1] = '{default: 0};
  int clr_cnt = 0;
  int lat, base, t;
  assign hready = hreadyout;
  always #2.5 mclk_in = ~mclk_in;
  bsl_exec #(.MEM_DIV(1)) uut (.mclk_in, .rstn_in, .instr_valid_in, .instr_word_in, .instr_word2_in,
    .lock_entry_in, .chan_busy_in, .instr_ready_out, .instr_done_out, .pc_out, .banks_out, .chan_bank_out,
    .lockout_out, .chan_start_out, .chan_clear_out, .chan_ignore_out, .chan_complete_out, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp);
  bsl_chan_model #(.REC_LEN(12)) chans (.clk_in(mclk_in), .rstn_in, .start_in(chan_start_out),
    .busy_out(chan_busy_in));
  always @(posedge mclk_in) begin
    cyc_cnt++;
    for (int c = 1; c <= 7; c++) begin
      if (chan_complete_out[c] === 1'b1) cmpl_cnt[c]++;
    end
    if (chan_clear_out[2] === 1'b1) clr_cnt++;
    if (cyc_cnt == 20000) begin
      num_errors++;
      results();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task results();
    $display("checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    @(posedge mclk_in);
    while (hready !== 1'b1) @(posedge mclk_in);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk_in);
    while (hready !== 1'b1) @(posedge mclk_in);
    q = hrdata;
  endtask : ahb
  task rdc(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask : rdc
  // Each instruction waits for its own done; lat counts edges from take to done.
  task ex(input logic [14:0] op, input logic [14:0] op2);
    @(posedge mclk_in);
    instr_valid_in <= 1'b1;
    instr_word_in <= op;
    instr_word2_in <= op2;
    @(posedge mclk_in);
    while (instr_ready_out !== 1'b1) @(posedge mclk_in);
    instr_valid_in <= 1'b0;
    lat = 0;
    while (instr_done_out !== 1'b1) begin
      @(posedge mclk_in);
      lat++;
    end
  endtask : ex
  task mul(input logic g, input logic [14:0] op, input logic [12:0] a, input logic [12:0] e);
    ahb(1'b1, bsl_pkg::ADDR_MODE, {31'h0000_0000, g});
    ahb(1'b1, bsl_pkg::ADDR_ACC, {19'h0_0000, a});
    ahb(1'b1, bsl_pkg::ADDR_PC, 32'h0000_0200);
    ex(op, 15'h0000);
    rdc(bsl_pkg::ADDR_ACC, {19'h0_0000, e});
    chk(pc_out, 15'h0201);
  endtask : mul
  task lk(input logic [14:0] op);
    ex(op, 15'h0000);
    ex(nop, 15'h0000);
    @(posedge mclk_in);
  endtask : lk
  function automatic logic [25:0] shf(input logic [25:0] x, input int wd, input logic lft, input int n);
    for (int i = 0; i < n; i++) begin
      x = lft ? ({x[24:0], 1'b0} | 26'(x[wd-1])) : ((x >> 1) | (26'(x[wd-1]) << (wd - 1)));
    end
    return x & ((26'h1 << wd) - 26'h1);
  endfunction : shf
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    nop = {bsl_pkg::F_ACC_RS, 6'h00};
    repeat (2) @(posedge mclk_in);
    rstn_in <= 1'b1;
    rdc(bsl_pkg::ADDR_BANKS, 32'h0000_0000);
    rdc(bsl_pkg::ADDR_LOCK, 32'h0000_0000);
    rdc(8'h40, 32'h0000_0000);
    chk(hresp, 32'h0000_0000);
    $display("reset test done");
    mul(1'b0, bsl_pkg::OP_TIMES_TEN, 13'h000C, 13'h0078);
    base = lat;
    mul(1'b0, bsl_pkg::OP_TIMES_TEN, 13'h019A, 13'h0005);
    mul(1'b0, bsl_pkg::OP_TIMES_TEN, 13'h00CD, 13'h1802);
    mul(1'b1, bsl_pkg::OP_TIMES_TEN, 13'h00CD, 13'h0802);
    mul(1'b0, bsl_pkg::OP_TIMES_HUNDRED, 13'h0014, 13'h07D0);
    mul(1'b0, bsl_pkg::OP_TIMES_HUNDRED, 13'h0029, 13'h0005);
    mul(1'b1, bsl_pkg::OP_TIMES_HUNDRED, 13'h0015, 13'h0834);
    $display("multiply test done");
    // Compatibility mode, where a 12-bit shifter would differ.
    ahb(1'b1, bsl_pkg::ADDR_MODE, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      ahb(1'b1, bsl_pkg::ADDR_ACC, 32'h0000_1A05);
      ahb(1'b1, bsl_pkg::ADDR_EXT, 32'h0000_0C33);
      ahb(1'b1, bsl_pkg::ADDR_PC, 32'h0000_0100);
      ex({sop[i], 6'(scnt[i])}, 15'h0000);
      v = (i < 2) ? 26'h1A05 : (i < 4) ? 26'h0C33 : {13'h1A05, 13'h0C33};
      r = shf(v, (i < 4) ? 13 : 26, i[0], scnt[i]);
      rdc(bsl_pkg::ADDR_ACC, (i < 2) ? r[12:0] : (i < 4) ? 13'h1A05 : r[25:13]);
      rdc(bsl_pkg::ADDR_EXT, (i < 2) ? 13'h0C33 : r[12:0]);
      chk(pc_out, 15'h0101);
      chk(lat - base, (scnt[i] > 7) ? scnt[i] - 7 : 0);
    end
    $display("shift test done");
    ahb(1'b1, bsl_pkg::ADDR_ACC, 32'h0000_0123);
    eb = '0;
    for (int k = 1; k <= 8; k++) begin
      ahb(1'b1, bsl_pkg::ADDR_PC, 32'h0000_0040);
      ex((k < 8) ? 15'(k * 9) : 15'h0065, 15'h0000);
      if (k < 8 && k[0]) eb.rel = 6'(k);
      if (k < 8 && k[1]) eb.ind = 6'(k);
      if (k < 8 && k[2]) eb.dir = 6'(k);
      if (k == 8) eb.bbuf = 6'h05;
      chk(banks_out, eb);
      chk(pc_out, (k < 8 && k[0]) ? 15'h0123 : 15'h0041);
      rdc(bsl_pkg::ADDR_ACC, 32'h0000_0123);
    end
    ahb(1'b1, bsl_pkg::ADDR_ACC, {19'h0_0000, 2'h3, 5'h15, 1'b1, 5'h0A});
    ahb(1'b1, bsl_pkg::ADDR_EXT, {19'h0_0000, 2'h3, 5'h03, 1'b1, 5'h1C});
    ex(bsl_pkg::OP_PAIR_TO_BANKS_JUMP, 15'h2345);
    eb = {6'h15, 6'h0A, 6'h03, 6'h1C};
    chk(banks_out, eb);
    chk(pc_out, 15'h2345);
    chk(lat - base, 1);
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, bsl_pkg::ADDR_PC, 32'h0000_0040);
      ex({wop[i], 6'(40 + i)}, 15'h1234);
      if (i < 2) eb.rel = 6'(40 + i);
      if (i == 1 || i == 2) eb.dir = 6'(40 + i);
      if (i == 3) eb.ind = 6'(40 + i);
      chk(banks_out, eb);
      chk(pc_out, (i < 2) ? 15'h1234 : 15'h0041);
      chk(lat - base, (i < 2) ? 1 : 0);
    end
    $display("bank test done");
    ahb(1'b1, bsl_pkg::ADDR_MODE, 32'h0000_0001);
    ex({bsl_pkg::F_LOCK, bsl_pkg::S_LOCK, 3'h3}, 15'h0000);
    @(posedge mclk_in);
    chk(lockout_out, 8'h00);
    lk(nop);
    chk(lockout_out, 8'h08);
    lk({bsl_pkg::F_LOCK, bsl_pkg::S_LOCK, 3'h0});
    chk(lockout_out, 8'h09);
    lk(bsl_pkg::OP_UNLOCK_INTERRUPTS);
    chk(lockout_out, 8'h08);
    lk({bsl_pkg::F_LOCK, bsl_pkg::S_LOCK, 3'h1});
    lk(bsl_pkg::OP_UNLOCK_INTERRUPTS);
    chk(lockout_out, 8'h0A);
    ahb(1'b1, bsl_pkg::ADDR_MODE, 32'h0000_0000);
    lk(bsl_pkg::OP_UNLOCK_INTERRUPTS);
    chk(lockout_out, 8'h08);
    lk({bsl_pkg::F_LOCK, bsl_pkg::S_UNLOCK, 3'h3});
    chk(lockout_out, 8'h00);
    @(posedge mclk_in);
    lock_entry_in <= 1'b1;
    @(posedge mclk_in);
    lock_entry_in <= 1'b0;
    @(posedge mclk_in);
    chk(lockout_out, 8'h01);
    $display("lockout test done");
    w = {bsl_pkg::F_CHAN, bsl_pkg::S_CHAN_INPUT, 3'h2};
    ahb(1'b1, bsl_pkg::ADDR_PC, 32'h0000_0300);
    ex(w, 15'h0777);
    chk(pc_out, 15'h0302);
    chk(lat - base, 0);
    ex(w, 15'h0777);
    chk(pc_out, 15'h0777);
    chk(lat - base, 1);
    ex({bsl_pkg::F_CHAN, bsl_pkg::S_CHAN_BANK, 3'h2}, 15'h0015);
    chk(chan_bank_out[2], 6'h15);
    for (t = 0; cmpl_cnt[2] == 0 && t < 100; t++) @(posedge mclk_in);
    chk(cmpl_cnt[2], 1);
    ex(w, 15'h0777);
    ex({bsl_pkg::F_LOCK, bsl_pkg::S_CLEAR, 3'h2}, 15'h0000);
    @(posedge mclk_in);
    chk(chan_ignore_out[2], 1'b1);
    ex(bsl_pkg::OP_START_BUFFERED_INPUT, 15'h0000);
    ex(bsl_pkg::OP_START_BUFFERED_INPUT, 15'h0555);
    chk(pc_out, 15'h0555);
    ex(bsl_pkg::OP_CLEAR_BUFFERS, 15'h0000);
    for (t = 0; chan_busy_in !== 7'h00 && t < 100; t++) @(posedge mclk_in);
    repeat (8) @(posedge mclk_in);
    chk(cmpl_cnt[2], 1);
    chk(cmpl_cnt[1], 0);
    chk(clr_cnt, 2);
    chk(chan_ignore_out, 7'h00);
    $display("channel test done");
    results();
  end
endmodule : test_bsl_exec
